// >>> rtl/warm_reset_seq.sv
/*
 * Warm reset and upgrade-present power-down sequencer of the processor.
 * Holds config_control_2 and the cache valid/dirty status bits and
 * decides between run, cold reset, warm reset and power-down.
 * Assumes cold reset arrives synchronous on reset_i; warm_reset_i and
 * upgrade_present_n_i are asynchronous board pins.
 */
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: Upgrade low floats outputs, enters power-down
// RULE2: Warm reset aborts work, enters reset state
// RULE3: Warm reset sampled only at clock edge
// RULE4: Warm reset keeps cache bits and config
// RULE5: Cold and warm together: cold wins
// RULE6: Warm reset ignored until enable bit set
// RULE7: Board gives warm pulse cold-reset timing
// RULE8: Board avoids resets during system management mode
// RULE9: In reset only bus hold request honoured; code acks hold in warm reset only, not during cold reset
// RULE10: Both pins pass two-stage synchroniser
module warm_reset_seq
#(
   parameter int unsigned LINES = 128,
   parameter int unsigned DWORDS = 4
)
(
   // Clock and reset
   input  wire logic                       mclk_i,
   input  wire logic                       reset_i,
   // Board pins
   input  wire logic                       warm_reset_i,
   input  wire logic                       upgrade_present_n_i,
   input  wire logic                       hold_req_i,
   // Core side outputs wanting to reach pins
   input  wire logic [31:0]                core_out_i,
   input  wire logic [31:0]                core_oe_i,
   // Software access to config_control_2
   input  wire rst_seq_pkg::cfg_write_s    cfg_wr_i,
   // Cache status updates from the core
   input  wire logic                       line_set_i,
   input  wire logic [$clog2(LINES)-1:0]   line_idx_i,
   input  wire logic [DWORDS-1:0]          dirty_set_i,
   // Pin drive
   output logic      [31:0]                pin_out_o,
   output logic      [31:0]                pin_oe_o,
   output logic                            hold_ack_o,
   // Status
   output logic [7:0]                      config_control_2_o,
   output rst_seq_pkg::seq_status_s        status_o,
   output rst_seq_pkg::seq_state_e         state_o,
   output logic [LINES-1:0]                line_valid_o,
   output logic [LINES*DWORDS-1:0]         line_dirty_o
);

   logic                     warm_sync;
   logic                     up_n_sync;
   logic [7:0]               config_control_2;
   logic                     warm_reset_enable_bit;
   logic                     warm_take;
   rst_seq_pkg::seq_state_e  state;
   rst_seq_pkg::seq_state_e  next_state;
   logic [DWORDS-1:0]        dirty [LINES];

   // Width of a line index, for matching it against the loop index
   localparam int unsigned IDX_W = $clog2(LINES);

   // Warm reset and upgrade pins cross into mclk_i before use; hold_req_i does not (see RULE10, see RULE3)
   pin_sync #(
      .WIDTH     (2),
      .RESET_VAL (2'h2)
   ) u_sync (
      .mclk_i    (mclk_i),
      .reset_i   (reset_i),
      .async_i   ({upgrade_present_n_i, warm_reset_i}),
      .sync_o    ({up_n_sync, warm_sync})
   );

   assign warm_reset_enable_bit =
      config_control_2[rst_seq_pkg::WARM_EN_BIT];

   // Warm reset honoured only once enabled (see RULE6)
   assign warm_take = warm_sync && warm_reset_enable_bit;

   // Decision of next state; cold has priority via reset_i (see RULE5)
   always_comb
   begin
      next_state = rst_seq_pkg::ST_RUN;
      case (state)
         rst_seq_pkg::ST_RUN,
         rst_seq_pkg::ST_COLD,
         rst_seq_pkg::ST_WARM,
         rst_seq_pkg::ST_POWERDOWN:
         begin
            if (!up_n_sync)
               next_state = rst_seq_pkg::ST_POWERDOWN; // see RULE1
            else if (warm_take)
               next_state = rst_seq_pkg::ST_WARM;      // see RULE2
            else
               next_state = rst_seq_pkg::ST_RUN;
         end
         default:
            next_state = rst_seq_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         state <= rst_seq_pkg::ST_COLD; // see RULE5
      else
         state <= next_state;
   end

   // Config register: only cold reset clears it (see RULE4, see RULE6)
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         config_control_2 <= rst_seq_pkg::CFG2_RESET;
      else if (cfg_wr_i.wr && state == rst_seq_pkg::ST_RUN)
         config_control_2 <= cfg_wr_i.data;
   end

   // Valid bits survive a warm reset (see RULE4)
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         line_valid_o <= {LINES{rst_seq_pkg::CACHE_BIT_RESET}};
      else if (line_set_i && state == rst_seq_pkg::ST_RUN)
         line_valid_o[line_idx_i] <= 1'b1;
   end

   // Dirty bits survive a warm reset (see RULE4)
   genvar g;
   generate
      for (g = 0; g < LINES; g++)
      begin : g_dirty
         always_ff @(posedge mclk_i)
         begin
            if (reset_i)
               dirty[g] <= {DWORDS{rst_seq_pkg::CACHE_BIT_RESET}};
            else if (line_set_i && state == rst_seq_pkg::ST_RUN &&
                     line_idx_i == IDX_W'(g))
               dirty[g] <= dirty[g] | dirty_set_i;
         end
         assign line_dirty_o[g*DWORDS +: DWORDS] = dirty[g];
      end
   endgenerate

   // Pin drive: float in power-down, quiet in reset (see RULE1, see RULE2)
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         pin_out_o <= 32'h0;
         pin_oe_o  <= 32'h0;
      end
      else if (next_state == rst_seq_pkg::ST_POWERDOWN)
      begin
         pin_out_o <= 32'h0;
         pin_oe_o  <= 32'h0;
      end
      else if (next_state == rst_seq_pkg::ST_WARM)
      begin
         pin_out_o <= 32'h0;
         pin_oe_o  <= 32'h0;
      end
      else
      begin
         pin_out_o <= core_out_i;
         pin_oe_o  <= core_oe_i;
      end
   end

   // In warm reset only hold request is answered; cold reset holds hold_ack_o low (see RULE9)
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         hold_ack_o <= 1'b0;
      else if (next_state == rst_seq_pkg::ST_POWERDOWN)
         hold_ack_o <= 1'b0;
      else
         hold_ack_o <= hold_req_i;
   end

   assign state_o            = state;
   assign config_control_2_o = config_control_2;

   always_comb
   begin
      status_o             = '0;
      status_o.core_reset  = (state == rst_seq_pkg::ST_COLD) ||
                             (state == rst_seq_pkg::ST_WARM);
      status_o.cold_wipe   = (state == rst_seq_pkg::ST_COLD);
      status_o.warm_wipe   = 1'b0; // see RULE4
      status_o.powerdown   = (state == rst_seq_pkg::ST_POWERDOWN);
      status_o.outputs_off = (state == rst_seq_pkg::ST_POWERDOWN);
      status_o.hold_only   = status_o.core_reset; // see RULE9
   end

endmodule
`default_nettype wire

// >>> common/rst_seq_pkg.sv
/*
 * Shared types and constants of the warm reset and upgrade power-down
 * sequencer. Assumes a single 100 MHz clock and synchronous reset.
 */
`default_nettype none
package rst_seq_pkg;

   // Synchroniser depth
   localparam int unsigned SYNC_STAGES = 2;

   // Cold reset vector of the second config control register
   localparam logic [7:0] CFG2_RESET = 8'h00;
   // Warm reset enable bit position in config_control_2
   localparam int unsigned WARM_EN_BIT = 1;
   // Reset vector of the cache status arrays
   localparam logic       CACHE_BIT_RESET = 1'h0;

   typedef enum logic [1:0] {
      ST_RUN       = 2'b00,
      ST_COLD      = 2'b01,
      ST_WARM      = 2'b10,
      ST_POWERDOWN = 2'b11
   } seq_state_e;

   // Software write to config_control_2
   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } cfg_write_s;

   // Status seen by the core
   typedef struct packed {
      logic       core_reset;
      logic       cold_wipe;
      logic       warm_wipe;
      logic       powerdown;
      logic       outputs_off;
      logic       hold_only;
   } seq_status_s;

endpackage
`default_nettype wire

// >>> rtl/pin_sync.sv
/*
 * Two-stage synchroniser for asynchronous pin levels, one per bit.
 * Assumes the inputs come from outside the mclk_i domain.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
#(
   parameter int unsigned WIDTH      = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             reset_i,
   // Levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         meta   <= RESET_VAL;
         sync_o <= RESET_VAL;
      end
      else
      begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule
`default_nettype wire

// >>> sim/rst_seq_checker.sv
/* Port assertions of warm_reset_seq.
   Assumes one clock, reset_i synchronous active high. */
`timescale 1ns/1ps
`default_nettype none
module rst_seq_checker #(parameter int unsigned LINES = 128)
(
   // Clock and reset
   input wire logic                     mclk_i,
   input wire logic                     reset_i,
   // Pins and status
   input wire logic                     warm_reset_i,
   input wire logic                     upgrade_present_n_i,
   input wire logic                     hold_req_i,
   input wire logic [31:0]              pin_oe_o,
   input wire logic                     hold_ack_o,
   input wire logic [7:0]               config_control_2_o,
   input wire rst_seq_pkg::seq_state_e  state_o,
   input wire logic [LINES-1:0]         line_valid_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   chk_idle_float: assert property (
      state_o != rst_seq_pkg::ST_RUN |-> pin_oe_o == '0)
      else $error("pins driven outside run");
   chk_pd_entry: assert property (
      !upgrade_present_n_i [*3] |=> state_o == rst_seq_pkg::ST_POWERDOWN)
      else $error("no power-down");
   chk_warm_entry: assert property (
      (warm_reset_i && config_control_2_o[1] && upgrade_present_n_i) [*3]
      |=> state_o == rst_seq_pkg::ST_WARM) else $error("no warm reset");
   chk_warm_gate: assert property (
      !config_control_2_o[1] && state_o == rst_seq_pkg::ST_RUN
      |=> state_o != rst_seq_pkg::ST_WARM) else $error("warm not gated");
   chk_warm_keep: assert property (
      state_o == rst_seq_pkg::ST_WARM |=> $stable(line_valid_o)
      && $stable(config_control_2_o)) else $error("warm lost state");
   chk_cold_wins: assert property (
      $fell(reset_i) |-> state_o == rst_seq_pkg::ST_COLD
      && config_control_2_o == 8'h00 && line_valid_o == '0)
      else $error("cold reset incomplete");
   chk_hold_follow: assert property (
      !state_o[0] ##1 !state_o[0] |-> hold_ack_o == $past(hold_req_i))
      else $error("hold ack wrong");
   chk_pd_no_ack: assert property (
      state_o == rst_seq_pkg::ST_POWERDOWN [*2] |-> !hold_ack_o)
      else $error("hold ack in power-down");
   cov_warm: cover property (state_o == rst_seq_pkg::ST_WARM);
   cov_pd: cover property (state_o == rst_seq_pkg::ST_POWERDOWN);
   cov_ack: cover property (hold_ack_o && state_o == rst_seq_pkg::ST_WARM);
endmodule
bind warm_reset_seq rst_seq_checker #(.LINES(LINES)) rst_seq_checker_inst
   (.mclk_i, .reset_i, .warm_reset_i, .upgrade_present_n_i, .hold_req_i,
    .pin_oe_o, .hold_ack_o, .config_control_2_o, .state_o, .line_valid_o);
`default_nettype wire

// >>> sim/board_ctl.sv
/* Board reset and power control model.
   Assumes the bench calls its tasks; pins change after rising edges. */
`timescale 1ns/1ps
`default_nettype none
module board_ctl
(
   // Clock
   input  wire logic mclk_i,
   // Pins toward the device
   output logic      warm_reset_o,
   output logic      upgrade_present_n_o
);
   initial
   begin
      warm_reset_o = 1'b0;
      upgrade_present_n_o = 1'b1;
   end
   // Held across edges, cold width, never in management mode
   task automatic warm_pulse(input int n);
      @(posedge mclk_i);
      warm_reset_o <= 1'b1;
      repeat (n) @(posedge mclk_i);
      warm_reset_o <= 1'b0;
   endtask
   task automatic upgrade_pulse(input int n);
      @(posedge mclk_i);
      upgrade_present_n_o <= 1'b0;
      repeat (n) @(posedge mclk_i);
      upgrade_present_n_o <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> sim/test_warm_reset_and_upgrade_powerdown.sv
/* Self-checking bench of warm_reset_seq.
   Assumes board_ctl drives the board pins. */
`timescale 1ns/1ps
`default_nettype none
module test_warm_reset_and_upgrade_powerdown;
   logic                       mclk_i = 1'b0;
   logic                       reset_i = 1'b1;
   logic                       hold_req_i = 1'b0;
   logic                       line_set_i = 1'b0;
   logic [31:0]                core_out_i = 32'h0000_a5a5;
   logic [31:0]                core_oe_i = 32'hffff_ffff;
   logic [6:0]                 line_idx_i = 7'h05;
   logic [3:0]                 dirty_set_i = 4'h1;
   rst_seq_pkg::cfg_write_s    cfg_wr_i = '0;
   wire logic                  warm_reset_i;
   wire logic                  upgrade_present_n_i;
   logic [31:0]                pin_oe_o;
   logic [31:0]                pin_out_o;
   rst_seq_pkg::seq_status_s   status_o;
   logic [511:0]               line_dirty_o;
   logic                       hold_ack_o;
   logic [7:0]                 config_control_2_o;
   rst_seq_pkg::seq_state_e    state_o;
   logic [127:0]               line_valid_o;
   int                         fail_count = 0;
   int                         tests_run = 0;
   int                         cyc = 0;
   board_ctl board_ctl_inst (.mclk_i(mclk_i), .warm_reset_o(warm_reset_i),
      .upgrade_present_n_o(upgrade_present_n_i));
   warm_reset_seq warm_reset_seq_inst (.mclk_i(mclk_i), .reset_i(reset_i),
      .warm_reset_i(warm_reset_i), .upgrade_present_n_i(upgrade_present_n_i),
      .hold_req_i(hold_req_i), .core_out_i(core_out_i),
      .core_oe_i(core_oe_i), .cfg_wr_i(cfg_wr_i), .line_set_i(line_set_i),
      .line_idx_i(line_idx_i), .dirty_set_i(dirty_set_i),
      .pin_out_o(pin_out_o),
      .pin_oe_o(pin_oe_o), .hold_ack_o(hold_ack_o),
      .config_control_2_o(config_control_2_o), .status_o(status_o),
      .state_o(state_o), .line_valid_o(line_valid_o),
      .line_dirty_o(line_dirty_o));
   initial forever #5 mclk_i = ~mclk_i;
   task automatic summarize;
      if (fail_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, s);
      tests_run++;
      if (e !== s)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wait_st(input rst_seq_pkg::seq_state_e s);
      for (int i = 0; i < 20 && state_o !== s; i++) @(negedge mclk_i);
   endtask
   task automatic t_disabled;
      @(posedge mclk_i) line_set_i <= 1'b1;
      @(posedge mclk_i) line_set_i <= 1'b0;
      fork board_ctl_inst.warm_pulse(4); join_none
      repeat (8) @(negedge mclk_i) chk("run", 0, state_o);
      chk("run oe", 32'hffff_ffff, pin_oe_o);
      chk("run out", 32'h0000_a5a5, pin_out_o);
   endtask
   task automatic t_warm;
      @(posedge mclk_i) cfg_wr_i <= '{wr: 1'b1, data: 8'h02};
      @(posedge mclk_i) cfg_wr_i <= '0;
      hold_req_i <= 1'b1;
      fork board_ctl_inst.warm_pulse(4); join_none
      repeat (4) @(negedge mclk_i);
      chk("early", 0, state_o);
      wait_st(rst_seq_pkg::ST_WARM);
      chk("warm", 2, state_o);
      chk("oe", 0, pin_oe_o);
      chk("valid", 1, line_valid_o[5]);
      chk("cfg", 8'h02, config_control_2_o);
      chk("ack", 1, hold_ack_o);
      chk("out", 0, pin_out_o);
      chk("core rst", 1, status_o.core_reset);
      chk("hold only", 1, status_o.hold_only);
      chk("dirty", 1, line_dirty_o[20]);
      wait_st(rst_seq_pkg::ST_RUN);
      chk("back", 0, state_o);
      chk("back oe", 32'hffff_ffff, pin_oe_o);
   endtask
   task automatic t_cold;
      @(posedge mclk_i) reset_i <= 1'b1;
      hold_req_i <= 1'b0;
      fork board_ctl_inst.warm_pulse(3); join_none
      repeat (6) @(posedge mclk_i);
      reset_i <= 1'b0;
      wait_st(rst_seq_pkg::ST_RUN);
      chk("cold cfg", 8'h00, config_control_2_o);
      chk("cold valid", 0, line_valid_o[5]);
      chk("cold dirty", 0, line_dirty_o[20]);
   endtask
   task automatic t_pd;
      @(posedge mclk_i) hold_req_i <= 1'b1;
      fork board_ctl_inst.upgrade_pulse(6); join_none
      wait_st(rst_seq_pkg::ST_POWERDOWN);
      @(negedge mclk_i) chk("pd", 3, state_o);
      chk("pd oe", 0, pin_oe_o);
      chk("pd ack", 0, hold_ack_o);
      chk("pd out", 0, pin_out_o);
      chk("pd flag", 1, status_o.powerdown);
      chk("pd float", 1, status_o.outputs_off);
      wait_st(rst_seq_pkg::ST_RUN);
      chk("pd back", 0, state_o);
   endtask
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fail_count++;
         summarize();
      end
   end
   initial
   begin
      repeat (3) @(posedge mclk_i);
      reset_i <= 1'b0;
      t_disabled();
      t_warm();
      t_cold();
      t_disabled();
      t_pd();
      summarize();
   end
endmodule
`default_nettype wire
